// *** logic/ebw_hold_ready.sv ***
// External bus interface: write ready wait states, alignment and bus hold/grant.
`timescale 1ns/1ns
`include "ebw_regs.svh"

//////////////////////////////////////////////////////////////////////////////////////////
module ebw_hold_ready
	import ebw_pkg::*;
#(
	parameter int TIM_DIV = `EBW_XTIM_NS / `EBW_SYS_CLK_NS
) (
	input  wire logic         sys_clk,
	input  wire logic         resetn,
	input  wire logic [3:0]   avs_address,
	input  wire logic         avs_read,
	input  wire logic         avs_write,
	input  wire logic [31:0]  avs_writedata,
	output logic [31:0]       avs_readdata,
	output logic              avs_waitrequest,
	input  wire ebw_cpu_req_t cpu_req,
	output logic              cpu_wait,
	output logic              cpu_done,
	output logic [31:0]       cpu_rdata,
	input  wire logic         ext_ready,
	input  wire logic         bus_request_n,
	output logic              bus_grant_n,
	output logic              bus_clock_out,
	input  wire logic [31:0]  ext_data_in,
	output ebw_pins_t         ext_pins
);

	localparam int TIM_HALF = TIM_DIV / 2;

	initial begin
		if (TIM_DIV < 2 || TIM_DIV > 255) begin
			$error("TIM_DIV must lie between 2 and 255");
		end
	end

	typedef struct packed {
		logic [7:0]  div;
		logic        bco;
		logic        rdy_s1;
		logic        rdy_s2;
		logic        req_s1;
		logic        req_s2;
		logic        req_lat;
		ebw_state_t  st;
		logic [3:0]  cnt;
		logic        we;
		logic [1:0]  zone;
		logic [31:0] rdata;
		logic        done;
		ebw_timing_t tim;
		logic        refuse;
		logic        ack;
		logic [31:0] rdat;
		ebw_pins_t   pins;
	} ebw_regs_t;

	ebw_regs_t r_ff;
	ebw_regs_t nxt_r;

	//////////////////////////////////////////////////////////////////////////////////////
	// Zone decode turns a zone number into active low selects.
	function automatic logic [2:0] zone_dec(input logic [1:0] z);
		logic [2:0] v;
		v = 3'h7;
		if (z < 2'h3) begin
			v[z] = 1'b0;
		end
		return v;
	endfunction : zone_dec

	function automatic logic [31:0] timing_word(input ebw_timing_t t);
		logic [31:0] w;
		w = 32'h0;
		w[`EBW_TIM_LEAD_LSB +: 3]   = t.lead;
		w[`EBW_TIM_ACTIVE_LSB +: 3] = t.active;
		w[`EBW_TIM_RDYEN_BIT]       = t.rdy_en;
		w[`EBW_TIM_RDYSEL_BIT]      = t.rdy_async;
		w[`EBW_TIM_BUS32_BIT]       = t.bus32;
		w[`EBW_TIM_HALF_BIT]        = t.half;
		return w;
	endfunction : timing_word

	logic       tick;
	logic       start_ok;
	logic [3:0] span;
	logic [3:0] point;
	logic       sample_due;
	logic       hold_want;
	logic       hold_now;
	logic       launch;

	//////////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_r = r_ff;
		tick = (r_ff.div == 8'(TIM_DIV - 1));
		span = {1'b0, r_ff.tim.lead} + {1'b0, r_ff.tim.active};
		point = span;
		if (r_ff.tim.rdy_async) begin
			point = (span > `EBW_ASYNC_EARLY) ? span - `EBW_ASYNC_EARLY : 4'h1;
		end
		sample_due = (r_ff.cnt + 4'h1) >= point;
		hold_want = ~r_ff.req_lat & ~r_ff.refuse;
		// The tick decides on the request value that it latches, which saves a tick.
		hold_now = ~r_ff.req_s2 & ~r_ff.refuse;
		start_ok = ~r_ff.tim.half | ~r_ff.bco;
		launch = 1'b0;
		nxt_r.done = 1'b0;

		nxt_r.div = tick ? 8'h0 : r_ff.div + 8'h1;
		nxt_r.rdy_s1 = ext_ready;
		nxt_r.rdy_s2 = r_ff.rdy_s1;
		nxt_r.req_s1 = bus_request_n;
		nxt_r.req_s2 = r_ff.req_s1;
		if (r_ff.tim.half) begin
			nxt_r.bco = tick ? ~r_ff.bco : r_ff.bco;
		end else begin
			nxt_r.bco = (nxt_r.div < 8'(TIM_HALF));
		end

		if (tick) begin
			nxt_r.req_lat = r_ff.req_s2;
			case (r_ff.st)
				EBW_IDLE: begin
					if (hold_now) begin
						nxt_r.st = EBW_FLOAT;
					end else if (cpu_req.valid && !r_ff.done) begin
						if (start_ok) begin
							launch = 1'b1;
						end else begin
							nxt_r.st = EBW_ALIGN;
						end
					end
				end
				EBW_ALIGN: begin
					launch = 1'b1;
				end
				EBW_ACC: begin
					nxt_r.cnt = r_ff.cnt + 4'h1;
					if (sample_due && (!r_ff.tim.rdy_en || r_ff.rdy_s2)) begin
						nxt_r.st = EBW_TRAIL;
						nxt_r.rdata = ext_data_in;
					end
				end
				EBW_TRAIL: begin
					nxt_r.st = EBW_IDLE;
					nxt_r.done = 1'b1;
				end
				EBW_FLOAT: begin
					if (!hold_now) begin
						nxt_r.st = EBW_IDLE;
					end
				end
				default: begin
					nxt_r.st = EBW_IDLE;
				end
			endcase
		end

		if (launch) begin
			nxt_r.st = EBW_ACC;
			nxt_r.cnt = 4'h0;
			nxt_r.we = cpu_req.we;
			nxt_r.zone = cpu_req.zone;
			nxt_r.pins.addr = cpu_req.addr;
			nxt_r.pins.data = cpu_req.wdata;
		end

		// Pin drive follows the next state; selects, read and low write strobes idle outside an access.
		nxt_r.pins.ctl_oe = (nxt_r.st != EBW_FLOAT);
		nxt_r.pins.addr_oe = nxt_r.pins.ctl_oe;
		nxt_r.pins.zcs_n = 3'h7;
		nxt_r.pins.we_low_n = 1'b1;
		nxt_r.pins.rd_n = 1'b1;
		nxt_r.pins.rnw = 1'b1;
		nxt_r.pins.data_oe = 1'b0;
		if (nxt_r.st == EBW_ACC || nxt_r.st == EBW_TRAIL) begin
			nxt_r.pins.zcs_n = zone_dec(nxt_r.zone);
			nxt_r.pins.rnw = ~nxt_r.we;
			nxt_r.pins.data_oe = nxt_r.we;
			if (nxt_r.st == EBW_ACC && nxt_r.cnt >= {1'b0, r_ff.tim.lead}) begin
				nxt_r.pins.we_low_n = ~nxt_r.we;
				nxt_r.pins.rd_n = nxt_r.we;
			end
		end
		// Register slave: every access waits exactly one cycle.
		nxt_r.ack = (avs_read | avs_write) & ~r_ff.ack;
		if (avs_write && r_ff.ack) begin
			case (avs_address)
					`EBW_OFS_TIMING: begin
						nxt_r.tim.lead = avs_writedata[`EBW_TIM_LEAD_LSB +: 3];
						nxt_r.tim.active = avs_writedata[`EBW_TIM_ACTIVE_LSB +: 3];
						nxt_r.tim.rdy_en = avs_writedata[`EBW_TIM_RDYEN_BIT];
						nxt_r.tim.rdy_async = avs_writedata[`EBW_TIM_RDYSEL_BIT];
						nxt_r.tim.bus32 = avs_writedata[`EBW_TIM_BUS32_BIT];
						nxt_r.tim.half = avs_writedata[`EBW_TIM_HALF_BIT];
					end
					`EBW_OFS_CTRL: begin
						nxt_r.refuse = avs_writedata[`EBW_CTRL_REFUSE_BIT];
					end
					default: begin
					end
			endcase
		end
		if ((avs_read | avs_write) && !r_ff.ack) begin
			if (avs_write) begin
				nxt_r.rdat = 32'h0;
			end else begin
				case (avs_address)
					`EBW_OFS_TIMING: nxt_r.rdat = timing_word(r_ff.tim);
					`EBW_OFS_CTRL: nxt_r.rdat = {31'h0, r_ff.refuse};
					`EBW_OFS_STATUS: nxt_r.rdat = {28'h0, ~r_ff.req_lat,
						(r_ff.st == EBW_ACC) && r_ff.tim.rdy_en && sample_due,
						(r_ff.st != EBW_IDLE) && (r_ff.st != EBW_FLOAT),
						r_ff.st == EBW_FLOAT};
					default: nxt_r.rdat = 32'h0;
				endcase
			end
		end
		// The high strobe follows the bus width that applies from the next cycle on.
		nxt_r.pins.we_high_n = nxt_r.tim.bus32 ? nxt_r.pins.we_low_n : nxt_r.pins.addr[0];
	end

	//////////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			r_ff <= '0;
			r_ff.rdy_s1 <= 1'b1;
			r_ff.rdy_s2 <= 1'b1;
			r_ff.st <= EBW_FLOAT;
			r_ff.tim.lead <= `EBW_RST_LEAD;
			r_ff.tim.active <= `EBW_RST_ACTIVE;
			r_ff.tim.rdy_en <= `EBW_RST_RDYEN;
			r_ff.tim.rdy_async <= `EBW_RST_RDYSEL;
			r_ff.tim.bus32 <= `EBW_RST_BUS32;
			r_ff.tim.half <= `EBW_RST_HALF;
			r_ff.refuse <= `EBW_RST_REFUSE;
			r_ff.pins.zcs_n <= 3'h7;
			r_ff.pins.we_low_n <= 1'b1;
			r_ff.pins.we_high_n <= 1'b1;
			r_ff.pins.rd_n <= 1'b1;
			r_ff.pins.rnw <= 1'b1;
		end else begin
			r_ff <= nxt_r;
		end
	end

	//////////////////////////////////////////////////////////////////////////////////////
	assign avs_waitrequest = (avs_read | avs_write) & ~r_ff.ack;
	assign avs_readdata    = r_ff.rdat;
	assign cpu_wait        = cpu_req.valid & ~r_ff.done;
	assign cpu_done        = r_ff.done;
	assign cpu_rdata       = r_ff.rdata;
	assign bus_grant_n     = (r_ff.st != EBW_FLOAT);
	assign bus_clock_out   = r_ff.bco;
	assign ext_pins        = r_ff.pins;

	//////////////////////////////////////////////////////////////////////////////////////
	// Checks on the block's own behaviour.
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	logic [7:0] rel_age;
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rel_age <= 8'h0;
		end else if (r_ff.st == EBW_FLOAT && !hold_want) begin
			rel_age <= rel_age + 8'h1;
		end else begin
			rel_age <= 8'h0;
		end
	end

	a_float_drops_pins: assert property (!bus_grant_n |-> !ext_pins.ctl_oe && !ext_pins.addr_oe
		&& !ext_pins.data_oe)
		else $error("granted bus still driven");
	a_align_idle_strb: assert property (r_ff.st == EBW_ALIGN |-> ext_pins.zcs_n == 3'h7
		&& ext_pins.we_low_n && ext_pins.rd_n)
		else $error("strobe active in alignment");
	a_idle_addr_hold: assert property (r_ff.st == EBW_IDLE && !launch |=> $stable(ext_pins.addr))
		else $error("idle address changed");
	a_we_high_mode: assert property (!r_ff.tim.bus32 && ext_pins.ctl_oe
		|-> ext_pins.we_high_n == ext_pins.addr[0])
		else $error("high strobe not address bit zero");
	a_no_early_done: assert property (r_ff.st == EBW_ACC && tick && !sample_due
		|=> r_ff.st == EBW_ACC)
		else $error("access ended before sample point");
	a_ready_low_holds: assert property (r_ff.st == EBW_ACC && tick && r_ff.tim.rdy_en
		&& !r_ff.rdy_s2 |=> r_ff.st == EBW_ACC)
		else $error("low ready did not hold access");
	a_async_point: assert property (r_ff.tim.rdy_async && span > 4'h2
		|-> point == span - 4'h2)
		else $error("async sample point wrong");
	a_ready_ends_acc: assert property (r_ff.st == EBW_ACC && tick && sample_due && r_ff.rdy_s2
		|=> r_ff.st == EBW_TRAIL)
		else $error("ready high did not complete");
	a_grant_release: assert property (rel_age <= 8'(TIM_DIV))
		else $error("grant held too long");
	a_no_float_busy: assert property (r_ff.st == EBW_ACC |=> r_ff.st != EBW_FLOAT)
		else $error("bus floated mid access");
	a_stall_granted: assert property (!bus_grant_n && cpu_req.valid |-> cpu_wait)
		else $error("cpu not stalled during grant");

	c_ready_wait: cover property (r_ff.st == EBW_ACC && tick && sample_due && !r_ff.rdy_s2);
	c_align_used: cover property (r_ff.st == EBW_ALIGN);
	c_hold_grant: cover property (bus_grant_n ##1 !bus_grant_n);
	c_refuse_drop: cover property (!bus_grant_n && r_ff.refuse ##[1:8] bus_grant_n);

endmodule : ebw_hold_ready

// *** logic/ebw_regs.svh ***
// Register offsets, field positions, reset values and timing counts of the external bus block.
`ifndef EBW_REGS_SVH
`define EBW_REGS_SVH
`define EBW_OFS_TIMING      4'h0
`define EBW_OFS_CTRL        4'h4
`define EBW_OFS_STATUS      4'h8
`define EBW_TIM_LEAD_LSB    0
`define EBW_TIM_ACTIVE_LSB  4
`define EBW_TIM_RDYEN_BIT   8
`define EBW_TIM_RDYSEL_BIT  9
`define EBW_TIM_BUS32_BIT   10
`define EBW_TIM_HALF_BIT    11
`define EBW_CTRL_REFUSE_BIT 0
`define EBW_RST_LEAD        3'h1
`define EBW_RST_ACTIVE      3'h3
`define EBW_RST_RDYEN       1'h0
`define EBW_RST_RDYSEL      1'h0
`define EBW_RST_BUS32       1'h1
`define EBW_RST_HALF        1'h0
`define EBW_RST_REFUSE      1'h0
`define EBW_SYS_CLK_NS      20
`define EBW_XTIM_NS         40
`define EBW_ASYNC_EARLY     4'h2
`endif

// *** logic/ebw_pkg.sv ***
// Types shared by the external bus write-ready and hold block.
package ebw_pkg;
	typedef enum logic [4:0] {
		EBW_IDLE  = 5'b00001,
		EBW_ALIGN = 5'b00010,
		EBW_ACC   = 5'b00100,
		EBW_TRAIL = 5'b01000,
		EBW_FLOAT = 5'b10000
	} ebw_state_t;

	typedef struct packed {
		logic        valid;
		logic        we;
		logic [1:0]  zone;
		logic [19:0] addr;
		logic [31:0] wdata;
	} ebw_cpu_req_t;

	typedef struct packed {
		logic [2:0] lead;
		logic [2:0] active;
		logic       rdy_en;
		logic       rdy_async;
		logic       bus32;
		logic       half;
	} ebw_timing_t;

	typedef struct packed {
		logic [19:0] addr;
		logic        addr_oe;
		logic [31:0] data;
		logic        data_oe;
		logic        we_low_n;
		logic        we_high_n;
		logic        rd_n;
		logic        rnw;
		logic [2:0]  zcs_n;
		logic        ctl_oe;
	} ebw_pins_t;
endpackage : ebw_pkg

// *** verification/ebw_ext_model.sv ***
// Far side model: external memory answering with ready and a master asking for the bus.
`timescale 1ns/1ns
module ebw_ext_model
	import ebw_pkg::*;
(
	input  wire ebw_pins_t  pins,
	input  wire logic       hold_want,
	input  wire logic [3:0] wait_ticks,
	output logic            ext_ready,
	output logic            bus_request_n,
	output logic [31:0]     ext_data_in
);
	logic       lclk;
	logic       tog;
	logic       sel;
	logic [3:0] cnt;
	initial begin
		lclk = 1'b0;
		tog = 1'b0;
		bus_request_n = 1'b1;
		#7;
		forever #80 lclk = ~lclk;
	end
	assign sel = pins.ctl_oe && (pins.zcs_n != 3'h7);
	// Ready answers after the asked number of link ticks; unselected it toggles.
	assign ext_ready = sel ? (cnt >= wait_ticks) : tog;
	assign ext_data_in = {16{tog, ~tog}};
	always @(posedge lclk) begin
		tog <= ~tog;
		bus_request_n <= ~hold_want;
	end
	// The wait count restarts as soon as the zone select goes away.
	always @(posedge lclk or negedge sel) begin
		if (!sel) cnt <= 4'h0;
		else if (cnt != 4'hf) cnt <= cnt + 4'h1;
	end
endmodule : ebw_ext_model

// *** verification/tb_top.sv ***
// Self-checking bench of the external bus write-ready and hold block.
`timescale 1ns/1ns
module tb_top
	import ebw_pkg::*;
;
	logic sys_clk, resetn, avs_read, avs_write, avs_waitrequest;
	logic cpu_wait, cpu_done, ext_ready, bus_request_n, bus_grant_n, bus_clock_out;
	logic hold_want, ok;
	logic [3:0] avs_address, wait_ticks;
	logic [31:0] avs_writedata, avs_readdata, cpu_rdata, ext_data_in, rd;
	ebw_cpu_req_t cpu_req;
	ebw_pins_t ext_pins, snap;
	logic [1:0] m;
	int error_cnt, check_count, n, lat, rdy_at, ls;
	ebw_hold_ready #(.TIM_DIV(2)) uut (.sys_clk(sys_clk), .resetn(resetn),
		.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
		.avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .cpu_req(cpu_req), .cpu_wait(cpu_wait),
		.cpu_done(cpu_done), .cpu_rdata(cpu_rdata), .ext_ready(ext_ready),
		.bus_request_n(bus_request_n), .bus_grant_n(bus_grant_n),
		.bus_clock_out(bus_clock_out), .ext_data_in(ext_data_in), .ext_pins(ext_pins));
	ebw_ext_model far (.pins(ext_pins), .hold_want(hold_want), .wait_ticks(wait_ticks),
		.ext_ready(ext_ready), .bus_request_n(bus_request_n), .ext_data_in(ext_data_in));
	//////////////////////////////////////////////////////////////////////////////////////
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task av(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : av
	task go(input logic [19:0] a);
		@(posedge sys_clk);
		cpu_req <= '{1'b1, 1'b1, 2'h0, a, {12'h0, a}};
		lat = 0;
		rdy_at = 0;
		do begin
			@(posedge sys_clk);
			lat++;
			if (ext_pins.we_low_n === 1'b0) snap = ext_pins;
			if (ext_pins.we_low_n === 1'b0 && ext_ready && rdy_at == 0) rdy_at = lat;
		end while (cpu_done !== 1'b1 && lat < 200);
		cpu_req.valid <= 1'b0;
	endtask : go
	task grant_wait(input logic v);
		for (n = 0; n < 40 && bus_grant_n !== v; n++) @(posedge sys_clk);
	endtask : grant_wait
	task results;
		$display("errors %0d checks %0d", error_cnt, check_count);
		if (error_cnt == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : results
	//////////////////////////////////////////////////////////////////////////////////////
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end
	initial begin
		#400000;
		error_cnt++;
		results();
	end
	initial begin
		{resetn, avs_read, avs_write, avs_address, avs_writedata} = '0;
		cpu_req = '0;
		hold_want = 1'b1;
		wait_ticks = 4'h5;
		repeat (6) @(posedge sys_clk);
		chk("rst_float", 2'b00, {bus_grant_n, ext_pins.ctl_oe});
		resetn <= 1'b1;
		hold_want <= 1'b0;
		grant_wait(1'b1);
		av(0, 4'h0, 0);
		chk("timing", 32'h431, rd);
		av(0, 4'h4, 0);
		chk("ctrl", 0, rd);
		av(0, 4'hc, 0);
		chk("unmapped", 0, rd);
		go(20'habcde);
		chk("no_rdy_lat", 1, lat <= 14);
		chk("addr", 20'habcde, snap.addr);
		chk("data", 32'habcde, snap.data);
		chk("rdata", 1, cpu_rdata == 32'h55555555 || cpu_rdata == 32'haaaaaaaa);
		chk("ctl", 5'b11000, {snap.zcs_n, snap.rnw, snap.we_high_n});
		repeat (4) @(posedge sys_clk);
		chk("idle_addr", 23'h7abcde, {ext_pins.zcs_n, ext_pins.addr});
		wait_ticks = 4'h0;
		av(1, 4'h0, 32'h531);
		go(20'h00010);
		ls = lat;
		av(1, 4'h0, 32'h731);
		go(20'h00020);
		chk("async_early", 4, ls - lat);
		wait_ticks = 4'h3;
		for (int k = 0; k < 2; k++) begin
			av(1, 4'h0, k ? 32'h731 : 32'h531);
			go(20'h00030);
			chk("rdy_wait", 1, rdy_at > 2 && lat > rdy_at && lat - rdy_at <= 10);
		end
		av(1, 4'h0, 32'h831);
		for (int k = 0; k < 2; k++) begin
			go(20'h12344 + k);
			chk("we_high_a0", k, snap.we_high_n);
			chk("half_done", 1, cpu_done);
		end
		av(1, 4'h0, 32'h431);
		hold_want <= 1'b1;
		wait (bus_request_n === 1'b0);
		for (n = 0; n < 40 && ext_pins.ctl_oe !== 1'b0; n++) @(posedge sys_clk);
		chk("float_t", 1, n <= 8);
		grant_wait(1'b0);
		chk("grant_t", 1, n <= 2);
		m = 2'b00;
		repeat (4) begin
			@(posedge sys_clk);
			m = m | (bus_clock_out ? 2'b10 : 2'b01);
		end
		chk("bclk_runs", 3, m);
		av(1, 4'h4, 1);
		grant_wait(1'b1);
		chk("refuse", 1, n <= 4 && ext_pins.ctl_oe);
		av(1, 4'h4, 0);
		grant_wait(1'b0);
		cpu_req <= '{1'b1, 1'b1, 2'h1, 20'h00077, 32'h77};
		repeat (20) @(posedge sys_clk);
		chk("stall", 2'b10, {cpu_wait, cpu_done});
		hold_want <= 1'b0;
		wait (bus_request_n === 1'b1);
		grant_wait(1'b1);
		chk("release_t", 1, n <= 6);
		for (n = 0; n < 60 && cpu_done !== 1'b1; n++) @(posedge sys_clk);
		chk("resume", 1, cpu_done);
		cpu_req.valid <= 1'b0;
		av(1, 4'h0, 32'h531);
		wait_ticks = 4'h6;
		cpu_req <= '{1'b1, 1'b1, 2'h2, 20'h00099, 32'h99};
		while (ext_pins.we_low_n !== 1'b0) @(posedge sys_clk);
		hold_want <= 1'b1;
		ok = 1'b1;
		for (n = 0; n < 200 && cpu_done !== 1'b1; n++) begin
			@(posedge sys_clk);
			ok = ok & (ext_pins.ctl_oe === 1'b1);
		end
		cpu_req.valid <= 1'b0;
		chk("pending", 2'b11, {ok, cpu_done});
		results();
	end
endmodule : tb_top
